// File: rtl/txq_defines.svh
`ifndef TXQ_DEFINES_SVH
`define TXQ_DEFINES_SVH
`define TXQ_A_SIZE_MSB 10
`define TXQ_A_SIZE_LSB 0
`define TXQ_A_OFF_MSB 20
`define TXQ_A_OFF_LSB 16
`define TXQ_A_OFFW_MSB 20
`define TXQ_A_OFFW_LSB 18
`define TXQ_A_OFFB_MSB 17
`define TXQ_A_OFFB_LSB 16
`define TXQ_A_FS 13
`define TXQ_A_LS 12
`define TXQ_A_ALIGN_MSB 25
`define TXQ_A_ALIGN_LSB 24
`define TXQ_ALIGN_16 2'h1
`define TXQ_ALIGN_32 2'h2
`define TXQ_B_TAG_MSB 31
`define TXQ_B_TAG_LSB 16
`define TXQ_B_CK 14
`define TXQ_B_LEN_MSB 10
`define TXQ_B_LEN_LSB 0
`define TXQ_ST_TAG_MSB 31
`define TXQ_ST_TAG_LSB 16
`define TXQ_ST_ES 15
`define TXQ_ST_LOSS 11
`define TXQ_ST_NOCAR 10
`define TXQ_ST_LATE 9
`define TXQ_ST_EXCOL 8
`define TXQ_ST_CC_MSB 6
`define TXQ_ST_CC_LSB 3
`define TXQ_ST_EXDEF 2
`define TXQ_ST_RSV1 1
`define TXQ_ST_DEFER 0
`define TXQ_KIND_MSB 33
`define TXQ_KIND_LSB 32
`endif

// File: rtl/txq_pkg.sv
`default_nettype none
`include "txq_defines.svh"
package txq_pkg;
   typedef enum logic [1:0] {
      TXQ_KIND_DATA = 2'h0,
      TXQ_KIND_CMDA = 2'h1,
      TXQ_KIND_CMDB = 2'h2,
      TXQ_KIND_LAST = 2'h3
   } txq_kind_type;
   typedef enum logic [1:0] {
      TXQ_WR_CMDA = 2'h0,
      TXQ_WR_CMDB = 2'h1,
      TXQ_WR_BODY = 2'h3
   } txq_wr_state_type;
   typedef enum logic [1:0] {
      TXQ_DR_IDLE = 2'h0,
      TXQ_DR_SEND = 2'h1,
      TXQ_DR_WAIT = 2'h3
   } txq_dr_state_type;
   typedef enum logic [1:0] {
      TXQ_H_IDLE = 2'h0,
      TXQ_H_CMDA = 2'h1,
      TXQ_H_CMDB = 2'h3,
      TXQ_H_BODY = 2'h2
   } txq_host_state_type;

   // Words the host writes for one buffer, alignment padding included
   function automatic logic [9:0] txq_total_words(input logic [31:0] a);
      logic [12:0] span;
      logic [12:0] r;
      span = 13'(a[`TXQ_A_OFF_MSB:`TXQ_A_OFF_LSB]) + 13'(a[`TXQ_A_SIZE_MSB:`TXQ_A_SIZE_LSB]);
      case (a[`TXQ_A_ALIGN_MSB:`TXQ_A_ALIGN_LSB])
         `TXQ_ALIGN_16: r = ((span + 13'h000F) >> 4) << 2;
         `TXQ_ALIGN_32: r = ((span + 13'h001F) >> 5) << 3;
         default: r = (span + 13'h0003) >> 2;
      endcase
      return r[9:0];
   endfunction

   // Words kept: sub-DWORD offset, payload and sub-DWORD padding
   function automatic logic [9:0] txq_keep_words(input logic [31:0] a);
      logic [12:0] span;
      span = 13'(a[`TXQ_A_OFFB_MSB:`TXQ_A_OFFB_LSB]) + 13'(a[`TXQ_A_SIZE_MSB:`TXQ_A_SIZE_LSB]) + 13'h0003;
      return span[11:2];
   endfunction
endpackage
`default_nettype wire

// File: rtl/txq_if.sv
`default_nettype none
interface txq_if;
   logic data_wr;
   logic [31:0] data_word;
   logic data_full;
   logic status_rd;
   logic status_avail;
   logic [31:0] status_word;
   logic [7:0] status_used_count;
   logic halt_set;
   logic tx_on_set;
   logic purge_data;
   logic purge_status;
   logic discard_allow;
   logic offload_enable;
   logic error_clear;
   logic transmitter_on;
   logic halt_req;
   logic halt_done_event;
   logic transmit_error_flag;
   modport device (
      input data_wr, data_word, status_rd, halt_set, tx_on_set, purge_data, purge_status,
      input discard_allow, offload_enable, error_clear,
      output data_full, status_avail, status_word, status_used_count, transmitter_on, halt_req,
      output halt_done_event, transmit_error_flag
   );
   modport host (
      output data_wr, data_word, status_rd, halt_set, tx_on_set, purge_data, purge_status,
      output discard_allow, offload_enable, error_clear,
      input data_full, status_avail, status_word, status_used_count, transmitter_on, halt_req,
      input halt_done_event, transmit_error_flag
   );
endinterface
`default_nettype wire

// File: rtl/txq_device.sv
// Summary of operation
// RULE1: One status word per packet, own FIFO
// RULE2: Full status FIFO suspends transmission until read
// RULE3: Discard-allow keeps transmitter running when full
// RULE4: Overrun holds used count zero, writes stop
// RULE5: Discard-allow overrun raises no error flag
// RULE6: Status upper half carries packet tag
// RULE7: Error summary ORs bits 11,10,9,8,2,1
// RULE8: Bits 11,10 report carrier lost, absent
// RULE9: Bit 9 reports late collision abort
// RULE10: Bit 8 reports sixteen-collision abandon
// RULE11: Bits 6:3 carry collision count
// RULE12: Bit 0 deferred, bit 2 excessive deferral
// RULE13: Reserved status bits always zero
// RULE14: First command always stored, second on first
// RULE15: Checksum preamble stored as packet data
// RULE16: Whole-DWORD offset, padding dropped; remainders kept
// RULE17: Checksum needs request, first segment, offload enable
// RULE18: Length mismatch flags error, transmitter continues
// RULE19: Second command must match across buffers
// RULE20: Data overrun, strict status overrun flag error
// RULE21: Halt finishes frame, clears bits, pulses done
// RULE22: Restart by transmitter on, queued frames resume
// RULE23: Second command bits 10:0 give byte count
`default_nettype none
`include "txq_defines.svh"
module txq_device
   import txq_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int SDEPTH = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   txq_if.device bus,
   output logic o_frame_valid,
   output logic [31:0] o_frame_word,
   output logic o_frame_last,
   input wire logic i_frame_ready,
   output logic o_checksum_enable,
   input wire logic i_mac_done,
   input wire logic i_loss_carrier,
   input wire logic i_no_carrier,
   input wire logic i_late_collision,
   input wire logic i_excess_collisions,
   input wire logic [3:0] i_collision_count,
   input wire logic i_deferral_check_enable,
   input wire logic i_excess_deferral,
   input wire logic i_deferred
);
   localparam int AW = $clog2(DEPTH);
   localparam int SW = $clog2(SDEPTH);
   localparam logic [AW:0] DCAP = (AW + 1)'(DEPTH);
   localparam logic [SW:0] SCAP = (SW + 1)'(SDEPTH);

   txq_wr_state_type wr_state_reg, wr_state_next;
   logic [31:0] cmda_reg, cmda_next;
   logic [31:0] refb_reg, refb_next;
   logic [9:0] widx_reg, widx_next;
   logic [15:0] bytes_reg, bytes_next;
   logic push;
   logic [33:0] push_entry;
   logic err_set_wr;
   logic buf_end;
   logic [9:0] head;
   logic [9:0] keep;
   logic [9:0] total;

   logic [33:0] dmem_reg [DEPTH];
   logic [33:0] dmem_next [DEPTH];
   logic [AW:0] dwp_reg, dwp_next, drp_reg, drp_next;
   logic [31:0] smem_reg [SDEPTH];
   logic [31:0] smem_next [SDEPTH];
   logic [SW:0] swp_reg, swp_next, srp_reg, srp_next;
   txq_dr_state_type dr_state_reg, dr_state_next;
   logic [15:0] tag_reg, tag_next;
   logic fs_reg, fs_next;
   logic cks_reg, cks_next;
   logic hold_reg, hold_next;
   logic txon_reg, txon_next;
   logic halt_reg, halt_next;
   logic done_reg, done_next;
   logic err_reg, err_next;
   logic err_set;
   logic pop;
   logic spop;
   logic dfull, dempty, sfull, sempty;
   logic [AW:0] dcount;
   logic [SW:0] scount;
   logic [1:0] head_kind;
   logic [31:0] head_word;
   logic [31:0] stat;

   assign dcount = dwp_reg - drp_reg;
   assign scount = swp_reg - srp_reg;
   assign dfull = (dcount == DCAP);
   assign dempty = (dcount == '0);
   assign sfull = (scount == SCAP);
   assign sempty = (scount == '0);
   assign head_kind = dmem_reg[drp_reg[AW-1:0]][`TXQ_KIND_MSB:`TXQ_KIND_LSB];
   assign head_word = dmem_reg[drp_reg[AW-1:0]][31:0];

   // Write-side parser: strips command B of later buffers and whole-DWORD padding
   always_comb begin
      wr_state_next = wr_state_reg;
      cmda_next = cmda_reg;
      refb_next = refb_reg;
      widx_next = widx_reg;
      bytes_next = bytes_reg;
      push = 1'b0;
      push_entry = '0;
      err_set_wr = 1'b0;
      buf_end = 1'b0;
      head = 10'(cmda_reg[`TXQ_A_OFFW_MSB:`TXQ_A_OFFW_LSB]);
      keep = txq_keep_words(cmda_reg);
      total = txq_total_words(cmda_reg);
      if (bus.data_wr) begin
         case (wr_state_reg)
            TXQ_WR_CMDA: begin
               cmda_next = bus.data_word;
               push = 1'b1; // RULE14
               push_entry = {TXQ_KIND_CMDA, bus.data_word};
               wr_state_next = TXQ_WR_CMDB;
            end
            TXQ_WR_CMDB: begin
               widx_next = '0;
               if (cmda_reg[`TXQ_A_FS]) begin
                  push = 1'b1; // RULE14
                  push_entry = {TXQ_KIND_CMDB, bus.data_word};
                  refb_next = bus.data_word;
                  bytes_next = 16'(cmda_reg[`TXQ_A_SIZE_MSB:`TXQ_A_SIZE_LSB]);
               end else begin
                  err_set_wr = (bus.data_word != refb_reg); // RULE19
                  bytes_next = bytes_reg + 16'(cmda_reg[`TXQ_A_SIZE_MSB:`TXQ_A_SIZE_LSB]);
               end
               buf_end = (total == '0);
               wr_state_next = TXQ_WR_BODY;
            end
            TXQ_WR_BODY: begin
               widx_next = widx_reg + 10'h001;
               if (widx_reg >= head && widx_reg < head + keep) begin
                  push = 1'b1; // RULE16 RULE15
                  if (cmda_reg[`TXQ_A_LS] && widx_reg == head + keep - 10'h001) begin
                     push_entry = {TXQ_KIND_LAST, bus.data_word};
                  end else begin
                     push_entry = {TXQ_KIND_DATA, bus.data_word};
                  end
               end
               buf_end = (widx_reg == total - 10'h001);
            end
            default: wr_state_next = TXQ_WR_CMDA;
         endcase
      end
      if (buf_end) begin
         wr_state_next = TXQ_WR_CMDA;
         // Byte count excludes offset and padding
         if (cmda_reg[`TXQ_A_LS] && bytes_next != 16'(refb_next[`TXQ_B_LEN_MSB:`TXQ_B_LEN_LSB])) begin
            err_set_wr = 1'b1; // RULE18 RULE23
         end
      end
      if (bus.purge_data) begin
         wr_state_next = TXQ_WR_CMDA;
      end
   end

   always_comb begin
      stat = '0; // RULE13
      stat[`TXQ_ST_TAG_MSB:`TXQ_ST_TAG_LSB] = tag_reg; // RULE6
      stat[`TXQ_ST_LOSS] = i_loss_carrier; // RULE8
      stat[`TXQ_ST_NOCAR] = i_no_carrier; // RULE8
      stat[`TXQ_ST_LATE] = i_late_collision; // RULE9
      stat[`TXQ_ST_EXCOL] = i_excess_collisions; // RULE10
      stat[`TXQ_ST_CC_MSB:`TXQ_ST_CC_LSB] = i_collision_count; // RULE11
      stat[`TXQ_ST_EXDEF] = i_excess_deferral && i_deferral_check_enable; // RULE12
      stat[`TXQ_ST_DEFER] = i_deferred; // RULE12
      stat[`TXQ_ST_ES] = stat[`TXQ_ST_LOSS] | stat[`TXQ_ST_NOCAR] | stat[`TXQ_ST_LATE] |
                         stat[`TXQ_ST_EXCOL] | stat[`TXQ_ST_EXDEF] | stat[`TXQ_ST_RSV1]; // RULE7
   end

   // Drain, status queue and halt control
   always_comb begin
      dmem_next = dmem_reg;
      smem_next = smem_reg;
      dwp_next = dwp_reg;
      drp_next = drp_reg;
      swp_next = swp_reg;
      srp_next = srp_reg;
      dr_state_next = dr_state_reg;
      tag_next = tag_reg;
      fs_next = fs_reg;
      cks_next = cks_reg;
      txon_next = txon_reg;
      halt_next = halt_reg;
      done_next = 1'b0;
      pop = 1'b0;
      o_frame_valid = 1'b0;
      err_set = err_set_wr;
      spop = bus.status_rd && !sempty;
      hold_next = hold_reg && !spop; // RULE4
      if (push) begin
         if (dfull) begin
            err_set = 1'b1; // RULE20
         end else begin
            dmem_next[dwp_reg[AW-1:0]] = push_entry;
            dwp_next = dwp_reg + 1'b1;
         end
      end
      case (dr_state_reg)
         TXQ_DR_IDLE: begin
            if (halt_reg) begin
               halt_next = 1'b0; // RULE21
               txon_next = 1'b0;
               done_next = 1'b1;
            end else if (txon_reg && !dempty && !(sfull && !bus.discard_allow)) begin // RULE2 RULE3 RULE22
               case (head_kind)
                  TXQ_KIND_CMDA: begin
                     pop = 1'b1;
                     fs_next = head_word[`TXQ_A_FS];
                  end
                  TXQ_KIND_CMDB: begin
                     pop = 1'b1;
                     tag_next = head_word[`TXQ_B_TAG_MSB:`TXQ_B_TAG_LSB];
                     cks_next = head_word[`TXQ_B_CK] && fs_reg && bus.offload_enable; // RULE17
                  end
                  default: dr_state_next = TXQ_DR_SEND;
               endcase
            end
         end
         TXQ_DR_SEND: begin
            // Commands of middle buffers are skipped mid-frame
            if (!dempty) begin
               if (head_kind == TXQ_KIND_CMDA || head_kind == TXQ_KIND_CMDB) begin
                  pop = 1'b1;
               end else begin
                  o_frame_valid = 1'b1;
                  if (i_frame_ready) begin
                     pop = 1'b1;
                     if (head_kind == TXQ_KIND_LAST) begin
                        dr_state_next = TXQ_DR_WAIT;
                     end
                  end
               end
            end
         end
         TXQ_DR_WAIT: begin
            if (i_mac_done) begin
               dr_state_next = TXQ_DR_IDLE;
               if (!(hold_reg && !spop)) begin
                  if (!sfull || spop) begin
                     smem_next[swp_reg[SW-1:0]] = stat; // RULE1
                     swp_next = swp_reg + 1'b1;
                  end else if (bus.discard_allow) begin
                     hold_next = 1'b1; // RULE4 RULE5
                  end else begin
                     err_set = 1'b1; // RULE20
                  end
               end
            end
         end
         default: dr_state_next = TXQ_DR_IDLE;
      endcase
      if (pop) begin
         drp_next = drp_reg + 1'b1;
      end
      if (spop) begin
         srp_next = srp_reg + 1'b1;
      end
      if (bus.tx_on_set) begin
         txon_next = 1'b1; // RULE22
      end
      if (bus.halt_set) begin
         halt_next = 1'b1; // RULE21
      end
      if (bus.purge_data) begin
         dwp_next = '0;
         drp_next = '0;
         dr_state_next = TXQ_DR_IDLE;
      end
      if (bus.purge_status) begin
         swp_next = '0;
         srp_next = '0;
         hold_next = 1'b0;
      end
      // New error wins over a clear in the same cycle
      err_next = (err_reg && !bus.error_clear) || err_set; // RULE18
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         wr_state_reg <= TXQ_WR_CMDA;
         cmda_reg <= '0;
         refb_reg <= '0;
         widx_reg <= '0;
         bytes_reg <= '0;
         dwp_reg <= '0;
         drp_reg <= '0;
         swp_reg <= '0;
         srp_reg <= '0;
         dr_state_reg <= TXQ_DR_IDLE;
         tag_reg <= '0;
         fs_reg <= 1'b0;
         cks_reg <= 1'b0;
         hold_reg <= 1'b0;
         txon_reg <= 1'b0;
         halt_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         dmem_reg <= '{default: '0};
         smem_reg <= '{default: '0};
      end else begin
         wr_state_reg <= wr_state_next;
         cmda_reg <= cmda_next;
         refb_reg <= refb_next;
         widx_reg <= widx_next;
         bytes_reg <= bytes_next;
         dwp_reg <= dwp_next;
         drp_reg <= drp_next;
         swp_reg <= swp_next;
         srp_reg <= srp_next;
         dr_state_reg <= dr_state_next;
         tag_reg <= tag_next;
         fs_reg <= fs_next;
         cks_reg <= cks_next;
         hold_reg <= hold_next;
         txon_reg <= txon_next;
         halt_reg <= halt_next;
         done_reg <= done_next;
         err_reg <= err_next;
         dmem_reg <= dmem_next;
         smem_reg <= smem_next;
      end
   end

   assign o_frame_word = head_word;
   assign o_frame_last = (head_kind == TXQ_KIND_LAST);
   assign o_checksum_enable = cks_reg;
   assign bus.data_full = dfull;
   assign bus.status_avail = !sempty;
   assign bus.status_word = smem_reg[srp_reg[SW-1:0]];
   assign bus.status_used_count = hold_reg ? 8'h00 : 8'(scount); // RULE4
   assign bus.transmitter_on = txon_reg;
   assign bus.halt_req = halt_reg;
   assign bus.halt_done_event = done_reg;
   assign bus.transmit_error_flag = err_reg;
endmodule
`default_nettype wire

// File: rtl/txq_host.sv
`default_nettype none
`include "txq_defines.svh"
module txq_host
   import txq_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   txq_if.host bus,
   input wire logic i_buf_start,
   input wire logic [31:0] i_cmd_a,
   input wire logic [31:0] i_cmd_b,
   output logic o_buf_busy,
   input wire logic i_word_valid,
   input wire logic [31:0] i_word,
   output logic o_word_ready,
   output logic o_status_valid,
   output logic [31:0] o_status_word,
   input wire logic i_halt,
   input wire logic i_restart,
   input wire logic i_purge,
   input wire logic i_discard_allow,
   input wire logic i_offload_enable,
   input wire logic i_error_clear,
   output logic o_transmitter_on,
   output logic o_halt_done,
   output logic o_tx_error,
   output logic [7:0] o_status_used_count
);
   txq_host_state_type state_reg, state_next;
   logic [31:0] cmda_reg, cmda_next;
   logic [31:0] cmdb_reg, cmdb_next;
   logic [9:0] left_reg, left_next;
   logic stv_reg, stv_next;
   logic [31:0] stw_reg, stw_next;

   always_comb begin
      state_next = state_reg;
      cmda_next = cmda_reg;
      cmdb_next = cmdb_reg;
      left_next = left_reg;
      bus.data_wr = 1'b0;
      bus.data_word = '0;
      o_word_ready = 1'b0;
      case (state_reg)
         TXQ_H_IDLE: begin
            if (i_buf_start) begin
               cmda_next = i_cmd_a;
               // Later buffers repeat the first buffer's second command
               if (i_cmd_a[`TXQ_A_FS]) begin
                  cmdb_next = i_cmd_b; // RULE19
               end
               left_next = txq_total_words(i_cmd_a);
               state_next = TXQ_H_CMDA;
            end
         end
         TXQ_H_CMDA: begin
            if (!bus.data_full) begin
               bus.data_wr = 1'b1;
               bus.data_word = cmda_reg;
               state_next = TXQ_H_CMDB;
            end
         end
         TXQ_H_CMDB: begin
            if (!bus.data_full) begin
               bus.data_wr = 1'b1;
               bus.data_word = cmdb_reg; // RULE19 RULE23 RULE17
               state_next = (left_reg == '0) ? TXQ_H_IDLE : TXQ_H_BODY;
            end
         end
         TXQ_H_BODY: begin
            o_word_ready = !bus.data_full;
            if (i_word_valid && !bus.data_full) begin
               bus.data_wr = 1'b1;
               bus.data_word = i_word;
               left_next = left_reg - 10'h001;
               if (left_reg == 10'h001) begin
                  state_next = TXQ_H_IDLE;
               end
            end
         end
         default: state_next = TXQ_H_IDLE;
      endcase
      stv_next = bus.status_avail && !stv_reg;
      stw_next = stv_next ? bus.status_word : stw_reg;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_reg <= TXQ_H_IDLE;
         cmda_reg <= '0;
         cmdb_reg <= '0;
         left_reg <= '0;
         stv_reg <= 1'b0;
         stw_reg <= '0;
      end else begin
         state_reg <= state_next;
         cmda_reg <= cmda_next;
         cmdb_reg <= cmdb_next;
         left_reg <= left_next;
         stv_reg <= stv_next;
         stw_reg <= stw_next;
      end
   end

   assign bus.status_rd = stv_next;
   assign bus.halt_set = i_halt; // RULE21
   assign bus.tx_on_set = i_restart; // RULE22
   assign bus.purge_data = i_restart && i_purge;
   assign bus.purge_status = i_restart && i_purge;
   assign bus.discard_allow = i_discard_allow;
   assign bus.offload_enable = i_offload_enable; // RULE17
   assign bus.error_clear = i_error_clear;
   assign o_buf_busy = (state_reg != TXQ_H_IDLE);
   assign o_status_valid = stv_reg;
   assign o_status_word = stw_reg;
   assign o_transmitter_on = bus.transmitter_on;
   assign o_halt_done = bus.halt_done_event;
   assign o_tx_error = bus.transmit_error_flag;
   assign o_status_used_count = bus.status_used_count;
endmodule
`default_nettype wire

// File: tb/txq_checker_sva.sv
`default_nettype none
module txq_checker #(
   parameter int SDEPTH = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic data_wr,
   input wire logic data_full,
   input wire logic status_avail,
   input wire logic [31:0] status_word,
   input wire logic [7:0] status_used_count,
   input wire logic tx_on_set,
   input wire logic error_clear,
   input wire logic transmitter_on,
   input wire logic halt_req,
   input wire logic halt_done_event,
   input wire logic transmit_error_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   AST_ES: assert property (status_avail |-> status_word[15] == (|{status_word[11:8], status_word[2:1]}))
      else $error("summary bit wrong");
   AST_RSV: assert property (status_avail |-> {status_word[14:12], status_word[7], status_word[1]} == 5'h00)
      else $error("reserved status bit set");
   AST_HALT_CLR: assert property (halt_done_event |-> !transmitter_on && !halt_req)
      else $error("halt left bits set");
   AST_HALT_CAUSE: assert property (halt_done_event |-> $past(halt_req))
      else $error("halt done without request");
   AST_PULSE: assert property (halt_done_event |=> !halt_done_event)
      else $error("halt done longer than a cycle");
   AST_ON_SET: assert property (tx_on_set |=> transmitter_on)
      else $error("transmitter did not start");
   AST_ERR_HOLD: assert property (transmit_error_flag && !error_clear |=> transmit_error_flag)
      else $error("error flag dropped");
   AST_FULL_ERR: assert property (data_wr && data_full |=> transmit_error_flag)
      else $error("data overrun not flagged");
   AST_USED: assert property (!status_avail |-> status_used_count == 8'h00)
      else $error("count without status");
   AST_BOUND: assert property (status_used_count <= 8'(SDEPTH))
      else $error("count above depth");
endmodule
`default_nettype wire

// File: tb/tx_status_and_queue_control_bench.sv
`default_nettype none
module tx_status_and_queue_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 1'h0;
   logic rst_n = 1'h0;
   logic bs = 1'h0, wv = 1'h0, halt = 1'h0, rs = 1'h0, purge = 1'h0, disc = 1'h0, offl = 1'h0;
   logic ec = 1'h0, rdy = 1'h0, md = 1'h0, ce = 1'h0;
   logic [31:0] ca = 32'h0, cb = 32'h0, wd = 32'h0;
   logic [10:0] mst = 11'h000, m;
   logic fv, fl, cs, busy, wr, sv, on, hd, err;
   logic [31:0] fw, sw;
   logic [7:0] suc;
   logic [33:0] frame_q[$];
   logic [31:0] status_q[$];
   logic [15:0] tag_q[$];
   int checks = 0, fail_count = 0;
   always #50 i_clock = ~i_clock;
   txq_if bus_if ();
   txq_device #(.DEPTH(16), .SDEPTH(4)) u_txq_device (.i_clock(i_clock), .i_rst_n(rst_n), .bus(bus_if),
      .o_frame_valid(fv), .o_frame_word(fw), .o_frame_last(fl), .i_frame_ready(rdy), .o_checksum_enable(cs),
      .i_mac_done(md), .i_loss_carrier(mst[10]), .i_no_carrier(mst[9]), .i_late_collision(mst[8]),
      .i_excess_collisions(mst[7]), .i_collision_count(mst[6:3]), .i_deferral_check_enable(mst[2]),
      .i_excess_deferral(mst[1]), .i_deferred(mst[0]));
   txq_host u_txq_host (.i_clock(i_clock), .i_rst_n(rst_n), .bus(bus_if), .i_buf_start(bs), .i_cmd_a(ca),
      .i_cmd_b(cb), .o_buf_busy(busy), .i_word_valid(wv), .i_word(wd), .o_word_ready(wr), .o_status_valid(sv),
      .o_status_word(sw), .i_halt(halt), .i_restart(rs), .i_purge(purge), .i_discard_allow(disc),
      .i_offload_enable(offl), .i_error_clear(ec), .o_transmitter_on(on), .o_halt_done(hd), .o_tx_error(err),
      .o_status_used_count(suc));
   txq_checker #(.SDEPTH(4)) u_chk (.i_clock(i_clock), .i_rst_n(rst_n), .data_wr(bus_if.data_wr),
      .data_full(bus_if.data_full), .status_avail(bus_if.status_avail), .status_word(bus_if.status_word),
      .status_used_count(bus_if.status_used_count), .tx_on_set(bus_if.tx_on_set),
      .error_clear(bus_if.error_clear), .transmitter_on(bus_if.transmitter_on), .halt_req(bus_if.halt_req),
      .halt_done_event(bus_if.halt_done_event), .transmit_error_flag(bus_if.transmit_error_flag));
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Random MAC stalls; status noted when the last word leaves
   always @(posedge i_clock) begin
      rdy <= 1'($urandom);
      md <= (fv === 1'h1 && rdy && fl === 1'h1);
      if (fv === 1'h1 && rdy) begin
         check({cs, fl, fw}, frame_q.pop_front());
         if (fl === 1'h1) begin
            m = 11'($urandom);
            mst <= m;
            status_q.push_back({tag_q.pop_front(), (|m[10:7]) | (m[2] & m[1]), 3'h0, m[10:7], 1'h0, m[6:3],
               m[2] & m[1], 1'h0, m[0]});
         end
      end
   end
   always @(posedge i_clock) if (sv === 1'h1) check(34'(sw), 34'(status_q.pop_front()));
   task automatic send_buf(input logic fs, ls, ck, input logic [10:0] sz, len, input logic [4:0] off,
                           input logic [1:0] al, input logic [15:0] tag);
      int u, tot, keep, base;
      logic [31:0] w;
      u = (al == 2'h1) ? 16 : (al == 2'h2) ? 32 : 4;
      tot = (int'(off) + int'(sz) + u - 1) / u * u / 4;
      keep = (int'(off[1:0]) + int'(sz) + 3) / 4;
      base = int'(off[4:2]);
      do @(negedge i_clock); while (busy !== 1'h0);
      @(posedge i_clock);
      bs <= 1'h1;
      ca <= {6'h00, al, 3'h0, off, 2'h0, fs, ls, 1'h0, sz};
      cb <= {tag, 1'h0, ck, 3'h0, len};
      @(posedge i_clock);
      bs <= 1'h0;
      for (int i = 0; i < tot; i++) begin
         w = $urandom;
         wv <= 1'h1;
         wd <= w;
         if (i >= base && i < base + keep) frame_q.push_back({ce, ls && i == base + keep - 1, w});
         do @(negedge i_clock); while (wr !== 1'h1);
         @(posedge i_clock);
      end
      wv <= 1'h0;
   endtask
   task automatic one_pkt(input logic [10:0] sz, input logic [10:0] extra);
      logic [15:0] tag;
      logic ck;
      tag = 16'($urandom);
      ck = 1'($urandom);
      ce = ck & offl;
      tag_q.push_back(tag);
      send_buf(1'h1, 1'h1, ck, sz, sz + extra, 5'($urandom), 2'($urandom_range(0, 2)), tag);
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 3000 && tag_q.size() + status_q.size() + frame_q.size() != 0; k++) @(posedge i_clock);
      repeat (4) @(posedge i_clock);
      // Leftover notes mean a hang
      check(34'(tag_q.size() + status_q.size() + frame_q.size()), 34'h0);
      check(34'(suc), 34'h00);
   endtask
   task automatic clear_err(input logic exp);
      check(34'(err), 34'(exp));
      @(posedge i_clock) ec <= 1'h1;
      @(posedge i_clock) ec <= 1'h0;
      @(negedge i_clock) check(34'(err), 34'h0);
   endtask
   initial begin
      #2000000;
      fail_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h9A21));
      disc <= 1'($urandom);
      repeat (10) @(posedge i_clock);
      rst_n <= 1'h1;
      @(posedge i_clock) rs <= 1'h1;
      @(posedge i_clock) rs <= 1'h0;
      for (int n = 0; n < 14; n++) begin
         @(posedge i_clock) offl <= 1'($urandom);
         @(posedge i_clock);
         one_pkt(11'($urandom_range(1, 60)), 11'h000);
         wait_idle();
      end
      one_pkt(11'h014, 11'h001);
      wait_idle();
      clear_err(1'h1);
      // Host resends the first buffer's second command, so a flipped tag raises no error
      for (int b = 0; b < 2; b++) begin
         ce = 1'h0;
         tag_q.push_back(16'h1234);
         send_buf(1'h1, 1'h0, 1'h0, 11'h008, 11'h014, 5'($urandom), 2'h0, 16'h1234);
         send_buf(1'h0, 1'h1, 1'h0, 11'h00C, 11'h014, 5'($urandom), 2'h1, 16'h1234 ^ 16'(b));
         wait_idle();
         clear_err(1'h0);
      end
      @(posedge i_clock) halt <= 1'h1;
      @(posedge i_clock) halt <= 1'h0;
      for (int k = 0; k < 200 && hd !== 1'h1; k++) @(negedge i_clock);
      check(34'(hd), 34'h1);
      check(34'(on), 34'h0);
      one_pkt(11'h008, 11'h000);
      repeat (60) @(posedge i_clock);
      check(34'(tag_q.size()), 34'h1);
      @(posedge i_clock) rs <= 1'h1;
      @(posedge i_clock) rs <= 1'h0;
      wait_idle();
      check(34'(on), 34'h1);
      check(34'(tag_q.size()), 34'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
